/* File: hw/pwct_regs.svh */
// Purpose: register offsets, field positions, reset values for the pwm channel timer
// Assumes: axi4-lite, 32-bit data, one aligned word per register
// Notes:   definitions only
`ifndef PWCT_REGS_SVH
`define PWCT_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PWCT_OFF_CTRL     8'h00
`define PWCT_OFF_PERIOD   8'h04
`define PWCT_OFF_DUTY     8'h08
`define PWCT_OFF_COUNTER  8'h0c
`define PWCT_OFF_STATUS   8'h10

// ----------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------
`define PWCT_CTRL_RUN     0
`define PWCT_CTRL_START   1
`define PWCT_CTRL_CENTER  2
`define PWCT_CTRL_CHOICE  3
`define PWCT_CTRL_W       4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PWCT_RST_CTRL     4'h0
`define PWCT_RST_PERIOD   8'h00
`define PWCT_RST_DUTY     8'h00

// ----------------------------------------------------------------
// axi answers
// ----------------------------------------------------------------
`define PWCT_RESP_OKAY    2'h0
`define PWCT_RESP_SLVERR  2'h2

`endif

/* File: hw/pwct_pkg.sv */
// Purpose: shared types of the pwm channel timer
// Assumes: nothing
// Notes:   constants live in pwct_regs.svh
`default_nettype none
package pwct_pkg;
   typedef logic [7:0] pwct_byte_t;
   typedef enum logic {
      PWCT_BUS_IDLE,
      PWCT_BUS_RESP
   } pwct_bus_t;
endpackage : pwct_pkg
`default_nettype wire

/* File: hw/pwct_core.sv */
// Purpose: 8-bit left-aligned channel timer core, all state in the bus clock domain
// Assumes: tick_a / tick_b are one-cycle enables from the clock generator
// Notes:   center alignment not supported; the select bit only reads back
`default_nettype none
module pwct_core (
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire logic              tick_a,
   input  wire logic              tick_b,
   input  wire logic              group_b,
   input  wire logic              channel_run_bit,
   input  wire logic              start_high_select,
   input  wire logic              period_load,
   input  wire logic              duty_load,
   input  wire logic              counter_write,
   input  wire pwct_pkg::pwct_byte_t wr_value,
   output logic                   pwm_out,
   output pwct_pkg::pwct_byte_t   channel_counter,
   output pwct_pkg::pwct_byte_t   active_period,
   output pwct_pkg::pwct_byte_t   active_duty
);
   typedef struct packed {
      logic                 run_sync;
      logic                 out_ff;
      logic                 pin;
      pwct_pkg::pwct_byte_t cnt;
      pwct_pkg::pwct_byte_t per_buf;
      pwct_pkg::pwct_byte_t dty_buf;
      pwct_pkg::pwct_byte_t per_act;
      pwct_pkg::pwct_byte_t dty_act;
   } pwct_core_t;

   pwct_core_t st;
   pwct_core_t next_st;
   logic       tick;

   // ----------------------------------------------------------------
   // channel timer
   // ----------------------------------------------------------------
   always_comb begin
      tick = group_b ? tick_b : tick_a;
      next_st = st;
      // enable reaches the counter only at a selected-clock edge
      if (tick) begin
         next_st.run_sync = channel_run_bit;
      end
      if (period_load) begin
         next_st.per_buf = wr_value;
      end
      if (duty_load) begin
         next_st.dty_buf = wr_value;
      end
      if (!channel_run_bit) begin
         // disabled: latches follow the buffers directly
         if (period_load) begin
            next_st.per_act = wr_value;
         end else begin
            next_st.per_act = st.per_buf;
         end
         if (duty_load) begin
            next_st.dty_act = wr_value;
         end else begin
            next_st.dty_act = st.dty_buf;
         end
         if (tick && st.per_act == 8'h00) begin
            next_st.cnt = 8'h00;
         end
      end
      if (counter_write) begin
         next_st.cnt     = 8'h00;
         next_st.per_act = st.per_buf;
         next_st.dty_act = st.dty_buf;
         next_st.out_ff  = 1'b0;
      end else if (tick && st.run_sync && channel_run_bit) begin
         // up count only: left-aligned mode
         if (st.cnt == st.per_act - 8'h01 || st.per_act == 8'h00) begin
            next_st.cnt     = 8'h00;
            next_st.out_ff  = 1'b0;
            next_st.per_act = st.per_buf;
            next_st.dty_act = st.dty_buf;
         end else begin
            next_st.cnt = st.cnt + 8'h01;
            if (st.cnt + 8'h01 == st.dty_act) begin
               next_st.out_ff = ~st.out_ff;
            end
         end
      end
      // polarity picks q or q-bar of the output flip-flop
      next_st.pin = start_high_select ? ~next_st.out_ff : next_st.out_ff;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   always_comb begin
      pwm_out         = st.pin;
      channel_counter = st.cnt;
      active_period   = st.per_act;
      active_duty     = st.dty_act;
   end
endmodule : pwct_core
`default_nettype wire

/* File: hw/pwct_top.sv */
// Purpose: pwm channel timer with an axi4-lite register slave
// Assumes: 40 MHz clk_sys, synchronous active-high rst, tick inputs one cycle wide
// Notes:   one write and one read answered at a time; answer one cycle after acceptance
//
// The register offsets and register access over AXI4-Lite were left to the implementer.
`include "pwct_regs.svh"
`default_nettype none
module pwct_top (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        tick_a,
   input  wire logic        tick_b,
   input  wire logic        group_b,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             pwm_out
);
   typedef struct packed {
      logic                       awr;
      logic                       wr;
      logic                       bvalid;
      logic [1:0]                 bresp;
      logic                       arr;
      logic                       rvalid;
      logic [1:0]                 rresp;
      logic [31:0]                rdata;
      logic [`PWCT_CTRL_W-1:0]    ctrl;
      logic                       per_ld;
      logic                       dty_ld;
      logic                       cnt_wr;
      logic [7:0]                 wval;
   } pwct_top_t;

   pwct_top_t            st;
   pwct_top_t            next_st;
   pwct_pkg::pwct_byte_t cnt_q;
   pwct_pkg::pwct_byte_t per_q;
   pwct_pkg::pwct_byte_t dty_q;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   function automatic logic known(input logic [7:0] a);
      known = (a == `PWCT_OFF_CTRL) || (a == `PWCT_OFF_PERIOD) || (a == `PWCT_OFF_DUTY)
           || (a == `PWCT_OFF_COUNTER) || (a == `PWCT_OFF_STATUS);
   endfunction : known

   // ----------------------------------------------------------------
   // bus slave
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.per_ld = 1'b0;
      next_st.dty_ld = 1'b0;
      next_st.cnt_wr = 1'b0;
      next_st.awr = !st.bvalid && s_axi_awvalid && s_axi_wvalid && !st.awr;
      next_st.wr  = next_st.awr;
      if (st.awr) begin
         next_st.bvalid = 1'b1;
         next_st.bresp  = known(s_axi_awaddr) ? `PWCT_RESP_OKAY : `PWCT_RESP_SLVERR;
         next_st.wval   = s_axi_wdata[7:0];
         if (s_axi_wstrb[0]) begin
            case (s_axi_awaddr)
               `PWCT_OFF_CTRL: begin
                  next_st.ctrl = s_axi_wdata[`PWCT_CTRL_W-1:0];
               end
               `PWCT_OFF_PERIOD: begin
                  next_st.per_ld = 1'b1;
               end
               `PWCT_OFF_DUTY: begin
                  next_st.dty_ld = 1'b1;
               end
               `PWCT_OFF_COUNTER: begin
                  // any value clears the count
                  next_st.cnt_wr = 1'b1;
               end
               default: begin
               end
            endcase
         end
      end
      if (st.bvalid && s_axi_bready) begin
         next_st.bvalid = 1'b0;
      end
      next_st.arr = !st.rvalid && s_axi_arvalid && !st.arr;
      if (st.arr) begin
         next_st.rvalid = 1'b1;
         next_st.rresp  = known(s_axi_araddr) ? `PWCT_RESP_OKAY : `PWCT_RESP_SLVERR;
         case (s_axi_araddr)
            `PWCT_OFF_CTRL:    next_st.rdata = {28'h0000000, st.ctrl};
            `PWCT_OFF_PERIOD:  next_st.rdata = {24'h000000, per_q};
            `PWCT_OFF_DUTY:    next_st.rdata = {24'h000000, dty_q};
            `PWCT_OFF_COUNTER: next_st.rdata = {24'h000000, cnt_q};
            `PWCT_OFF_STATUS:  next_st.rdata = {23'h000000, pwm_out, cnt_q};
            default:           next_st.rdata = 32'h00000000;
         endcase
      end
      if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st      <= '0;
         st.ctrl <= `PWCT_RST_CTRL;
      end else begin
         st <= next_st;
      end
   end

   always_comb begin
      s_axi_awready = st.awr;
      s_axi_wready  = st.wr;
      s_axi_bvalid  = st.bvalid;
      s_axi_bresp   = st.bresp;
      s_axi_arready = st.arr;
      s_axi_rvalid  = st.rvalid;
      s_axi_rresp   = st.rresp;
      s_axi_rdata   = st.rdata;
   end

   // ----------------------------------------------------------------
   // channel
   // ----------------------------------------------------------------
   pwct_core u_core (
      .clk_sys           (clk_sys),
      .rst               (rst),
      .tick_a            (tick_a),
      .tick_b            (tick_b),
      .group_b           (group_b),
      .channel_run_bit   (st.ctrl[`PWCT_CTRL_RUN]),
      .start_high_select (st.ctrl[`PWCT_CTRL_START]),
      .period_load       (st.per_ld),
      .duty_load         (st.dty_ld),
      .counter_write     (st.cnt_wr),
      .wr_value          (st.wval),
      .pwm_out           (pwm_out),
      .channel_counter   (cnt_q),
      .active_period     (per_q),
      .active_duty       (dty_q)
   );
endmodule : pwct_top
`default_nettype wire

/* File: testbench/pwct_load_model.sv */
// Purpose: load on the waveform pin, measures high time and period
// Assumes: pin driven by the timer, sampled on clk_sys
// Notes:   counts in clk_sys cycles, rise to rise
`default_nettype none
module pwct_load_model (
   input  wire logic        clk_sys,
   input  wire logic        pwm_in,
   output logic [15:0]      high_cycles,
   output logic [15:0]      period_cycles
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] run  = 16'h0;
   logic [15:0] hi   = 16'h0;
   logic        last = 1'b0;
   // a rise closes one waveform cycle and opens the next
   always @(posedge clk_sys) begin
      last <= pwm_in;
      run <= (pwm_in & !last) ? 16'h1 : run + 16'h1;
      hi <= (pwm_in & !last) ? 16'h1 : hi + {15'h0, pwm_in};
      if (pwm_in & !last) begin
         period_cycles <= run;
         high_cycles <= hi;
      end
   end
endmodule : pwct_load_model
`default_nettype wire

/* File: testbench/pwct_properties.sv */
// Purpose: bus and waveform properties at the pins of pwct_top
// Assumes: synchronous active-high rst
// Notes:   sees ports only
`include "pwct_regs.svh"
`default_nettype none
module pwct_properties (
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        tick_a,
   input wire logic        tick_b,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        pwm_out
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   property p_wr_pair; s_axi_awready |-> s_axi_wready; endproperty
   a_wr_pair: assert property (p_wr_pair) else $error("write halves taken apart");
   property p_wr_resp; s_axi_awready |=> s_axi_bvalid; endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
   property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   property p_rd_resp; s_axi_arready |=> s_axi_rvalid; endproperty
   a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
   property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
   property p_rd_err;
      s_axi_arready && !(s_axi_araddr inside {`PWCT_OFF_CTRL, `PWCT_OFF_PERIOD,
         `PWCT_OFF_DUTY, `PWCT_OFF_COUNTER, `PWCT_OFF_STATUS})
      |=> s_axi_rresp == `PWCT_RESP_SLVERR && s_axi_rdata == 32'h0;
   endproperty
   a_rd_err: assert property (p_rd_err) else $error("unmapped read not refused");
   property p_rdata_hi; s_axi_rvalid |-> s_axi_rdata[31:9] == 23'h0; endproperty
   a_rdata_hi: assert property (p_rdata_hi) else $error("upper read bits set");
   property p_rst_out; disable iff (1'b0) rst |=> !pwm_out; endproperty
   a_rst_out: assert property (p_rst_out) else $error("output high after reset");
   // output moves only on a count tick or a register write landing
   property p_out_cause;
      $changed(pwm_out) |-> $past(tick_a | tick_b) || $past(tick_a | tick_b, 2)
         || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
   endproperty
   a_out_cause: assert property (p_out_cause) else $error("output moved unprompted");
   c_wr: cover property (s_axi_bvalid && s_axi_bready);
   c_err: cover property (s_axi_rvalid && s_axi_rresp == `PWCT_RESP_SLVERR);
   c_rise: cover property ($rose(pwm_out));
endmodule : pwct_properties
bind pwct_top pwct_properties i_pwct_properties (.clk_sys, .rst, .tick_a, .tick_b,
   .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_araddr,
   .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .pwm_out);
`default_nettype wire

/* File: testbench/tb_top.sv */
// Purpose: self-checking bench of pwct_top
// Assumes: 40 MHz clk_sys, ticks made here
// Notes:   tick_a every 4 cycles, tick_b every 6
`include "pwct_regs.svh"
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys, rst, tick_a, tick_b, group_b, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_arready, s_axi_rvalid, pwm_out;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [15:0] hi_c, per_c;
   int          num_errors = 0, checks_done = 0, cyc = 0;
   pwct_top i_pwct_top (.clk_sys, .rst, .tick_a, .tick_b, .group_b, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .pwm_out);
   pwct_load_model i_pwct_load_model (.clk_sys, .pwm_in(pwm_out), .high_cycles(hi_c),
      .period_cycles(per_c));
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   task automatic complete_run;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : complete_run
   // tick source stands in for the clock generator; also bounds a hang
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      tick_a <= (cyc % 4 == 3);
      tick_b <= (cyc % 6 == 5);
      if (cyc == 8000) begin
         num_errors++;
         complete_run();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      check({30'h0, s_axi_bresp}, {30'h0, er});
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
   task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0]  r;
      rd(a, d, r);
      check(d, e);
      check({30'h0, r}, {30'h0, er});
   endtask : rc
   task automatic t_reset;
      rc(`PWCT_OFF_CTRL, 32'h0, 2'h0);
      rc(`PWCT_OFF_COUNTER, 32'h0, 2'h0);
      rc(8'h14, 32'h0, `PWCT_RESP_SLVERR);
      wr(8'h14, 32'h1, `PWCT_RESP_SLVERR);
   endtask : t_reset
   task automatic t_wave(input logic pol, input logic grp);
      logic [31:0] t;
      t = grp ? 32'h6 : 32'h4;
      group_b <= grp;
      wr(`PWCT_OFF_CTRL, {30'h0, pol, 1'b0}, 2'h0);
      wr(`PWCT_OFF_PERIOD, 32'h4, 2'h0);
      wr(`PWCT_OFF_DUTY, 32'h1, 2'h0);
      rc(`PWCT_OFF_PERIOD, 32'h4, 2'h0);
      wr(`PWCT_OFF_COUNTER, 32'h5a, 2'h0);
      rc(`PWCT_OFF_COUNTER, 32'h0, 2'h0);
      wr(`PWCT_OFF_CTRL, {30'h0, pol, 1'b1}, 2'h0);
      repeat (120) @(posedge clk_sys);
      check({16'h0, per_c}, t * 4);
      check({16'h0, hi_c}, pol ? t : t * 3);
   endtask : t_wave
   task automatic t_hold;
      logic [31:0] c1, c2;
      logic [1:0]  r;
      wr(`PWCT_OFF_CTRL, 32'h2, 2'h0);
      wr(`PWCT_OFF_PERIOD, 32'h8, 2'h0);
      rd(`PWCT_OFF_COUNTER, c1, r);
      repeat (30) @(posedge clk_sys);
      rc(`PWCT_OFF_COUNTER, c1, 2'h0);
      check({31'h0, c1 < 32'h4}, 32'h1);
      wr(`PWCT_OFF_CTRL, 32'h3, 2'h0);
      // one tick to synchronise the enable, one more before the first count
      repeat (20) @(posedge clk_sys);
      rd(`PWCT_OFF_COUNTER, c2, r);
      check({31'h0, c2 > c1}, 32'h1);
   endtask : t_hold
   task automatic t_buffer;
      wr(`PWCT_OFF_COUNTER, 32'h0, 2'h0);
      wr(`PWCT_OFF_PERIOD, 32'hc, 2'h0);
      rc(`PWCT_OFF_PERIOD, 32'h8, 2'h0);
      repeat (100) @(posedge clk_sys);
      rc(`PWCT_OFF_PERIOD, 32'hc, 2'h0);
      repeat (160) @(posedge clk_sys);
      check({16'h0, per_c}, 32'd72);
      wr(`PWCT_OFF_CTRL, 32'h2, 2'h0);
      wr(`PWCT_OFF_PERIOD, 32'h0, 2'h0);
      // at least two b-side ticks pass while disabled with period zero
      repeat (12) @(posedge clk_sys);
      rc(`PWCT_OFF_COUNTER, 32'h0, 2'h0);
   endtask : t_buffer
   initial begin
      {rst, group_b, s_axi_awvalid, s_axi_wvalid} = 4'h8;
      {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hf;
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset();
      for (int p = 0; p < 4; p++) t_wave(p[1], p[0]);
      t_hold();
      t_buffer();
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
